// file: hdl/eqs_pkg.sv
// Package of constants for the equalizer status and override logic
package eqs_pkg;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL_OFS    = 8'h00;
   localparam logic [7:0] REG_STATUS_OFS  = 8'h04;
   localparam logic [7:0] REG_RESTART_OFS = 8'h08;

   // Control register fields
   localparam int CTRL_HOLD_BIT    = 0;
   localparam int CTRL_RESTART_BIT = 1;
   localparam logic CTRL_HOLD_RST  = 1'b0;

   // Status register fields
   localparam int ST_STATE_LSB     = 0;
   localparam int ST_SETTLED_BIT   = 2;
   localparam int ST_COLOR_BIT     = 3;
   localparam int ST_INVERT_BIT    = 4;
   localparam int ST_COLOR_OVR_BIT = 5;
   localparam int ST_INV_OVR_BIT   = 6;
   localparam int ST_HOLD_BIT      = 7;
   localparam int ST_BYPASS_BIT    = 8;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Settle qualification time and clock rate
   localparam int CLK_MHZ         = 200;
   localparam int SETTLE_TIME_NS  = 1000;
   localparam int SETTLE_CYCLES   = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;

   // Synchroniser lanes
   localparam int SYNC_HOLD      = 0;
   localparam int SYNC_COLOR     = 1;
   localparam int SYNC_COLOR_EXT = 2;
   localparam int SYNC_INV       = 3;
   localparam int SYNC_INV_EXT   = 4;
   localparam int SYNC_LANES     = 5;

   // Acquisition states
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ACQUIRE = 2'b01,
      ST_SETTLED = 2'b10
   } eqs_state_e;

endpackage

// file: hdl/eqs_tgl_if.sv
// Interface between the polarity pin toggle detector and its user
`timescale 1ns/1ps
interface eqs_tgl_if;
   logic level;       // Synchronised polarity pin level
   logic ext;         // Pin is driven from outside
   logic standalone;  // Serial interface not in use
   logic restart;     // One-cycle reacquire request

   modport det (input level, input ext, input standalone, output restart);
   modport src (output level, output ext, output standalone, input restart);
endinterface

// file: hdl/eqs_toggle_det.sv
// Detector of high-low-high or low-high-low toggles on the polarity pin
`timescale 1ns/1ps
module eqs_toggle_det
   import eqs_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   eqs_tgl_if.det    tgl
);

   logic       last_level;
   logic [1:0] edges;
   logic       restart;
   logic       next_last_level;
   logic [1:0] next_edges;
   logic       next_restart;

   // Count level changes while driven from outside; two make a toggle
   always_comb begin
      next_last_level = tgl.level;
      next_edges      = edges;
      next_restart    = 1'b0;
      if (!tgl.ext || !tgl.standalone) begin
         next_edges = 2'b00;
      end else if (tgl.level != last_level) begin
         if (edges == 2'b01) begin
            next_restart = 1'b1; // RQ7
            next_edges   = 2'b00;
         end else begin
            next_edges = 2'b01;
         end
      end
   end

   // State registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         last_level <= 1'b0;
         edges      <= 2'b00;
         restart    <= 1'b0;
      end else begin
         last_level <= next_last_level;
         edges      <= next_edges;
         restart    <= next_restart;
      end
   end

   assign tgl.restart = restart;

   a_toggle_standalone: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !$past(tgl.standalone) |-> !restart) else $error("Restart outside stand-alone"); // RQ7

   a_toggle_two_edges: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      restart |-> $past(tgl.ext) && ($past(tgl.level) != $past(last_level)))
      else $error("Restart without pin change"); // RQ7

endmodule // eqs_toggle_det

// file: hdl/eqs_status_pins.sv
// Status indicators, pin overrides and acquisition control of the equalizer
// Operation
// RQ1: Chroma pin shows burst presence when free
// RQ2: Driven chroma pin forces mono or colour
// RQ3: Chroma pin weakly driven unless overridden
// RQ4: Polarity pin shows detected inversion when free
// RQ5: Driven polarity pin sets chain inversion
// RQ6: Polarity pin weakly driven unless overridden
// RQ7: Polarity toggle restarts acquisition, stand-alone
// RQ8: Settled indicator high only once equalized
// RQ9: Equalizing never depends on indicator values
// RQ10: Hold low updates, hold high freezes
// RQ11: Board may tie hold to settled
// RQ12: Board ties unused hold low
// RQ13: Board grounds unused serial pins
// RQ14: Bypass high disables equalization, never floating
// RQ15: Synchronise hold and override pins first
`timescale 1ns/1ps
module eqs_status_pins
   import eqs_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input  wire logic              REF_CLK_I,
   input  wire logic              RST_N_I,
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
   input  wire logic              S_AXI_AWVALID_I,
   output wire logic              S_AXI_AWREADY_O,
   input  wire logic [31:0]       S_AXI_WDATA_I,
   input  wire logic [3:0]        S_AXI_WSTRB_I,
   input  wire logic              S_AXI_WVALID_I,
   output wire logic              S_AXI_WREADY_O,
   output wire logic [1:0]        S_AXI_BRESP_O,
   output wire logic              S_AXI_BVALID_O,
   input  wire logic              S_AXI_BREADY_I,
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
   input  wire logic              S_AXI_ARVALID_I,
   output wire logic              S_AXI_ARREADY_O,
   output wire logic [31:0]       S_AXI_RDATA_O,
   output wire logic [1:0]        S_AXI_RRESP_O,
   output wire logic              S_AXI_RVALID_O,
   input  wire logic              S_AXI_RREADY_I,
   input  wire logic              SIGNAL_PRESENT_I,
   input  wire logic              EQ_CONVERGED_I,
   input  wire logic              BURST_DETECTED_I,
   input  wire logic              POLARITY_INVERTED_I,
   input  wire logic              COLOR_I,
   input  wire logic              COLOR_EXT_I,
   output wire logic              COLOR_O,
   output wire logic              COLOR_OE_N_O,
   input  wire logic              INVERT_I,
   input  wire logic              INVERT_EXT_I,
   output wire logic              INVERT_O,
   output wire logic              INVERT_OE_N_O,
   input  wire logic              HOLD_I,
   input  wire logic              EQUALIZER_BYPASS_I,
   input  wire logic              SERIAL_SELECT_I,
   output wire logic              EQ_SETTLED_O,
   output wire logic              EQ_UPDATE_O,
   output wire logic              EQ_BYPASS_O,
   output wire logic              COLOR_MODE_O,
   output wire logic              CHAIN_INVERT_O,
   output wire logic              REACQUIRE_O
);

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);

   // Synchroniser stages and their raw inputs
   logic [SYNC_LANES-1:0] sync_raw;
   logic [SYNC_LANES-1:0] sync_1;
   logic [SYNC_LANES-1:0] sync_2;

   assign sync_raw[SYNC_HOLD]      = HOLD_I;
   assign sync_raw[SYNC_COLOR]     = COLOR_I;
   assign sync_raw[SYNC_COLOR_EXT] = COLOR_EXT_I;
   assign sync_raw[SYNC_INV]       = INVERT_I;
   assign sync_raw[SYNC_INV_EXT]   = INVERT_EXT_I;

   // Two flip-flop synchroniser per lane; only stage two is used
   generate
      for (genvar i = 0; i < SYNC_LANES; i++) begin : g_sync
         always_ff @(posedge REF_CLK_I) begin
            if (!RST_N_I) begin
               sync_1[i] <= 1'b0;
               sync_2[i] <= 1'b0;
            end else begin
               sync_1[i] <= sync_raw[i]; // RQ15
               sync_2[i] <= sync_1[i];
            end
         end
      end
   endgenerate

   // Register bus state
   logic              aw_have;
   logic [ADDR_W-1:0] aw_addr;
   logic              w_have;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              bvalid;
   logic [1:0]        bresp;
   logic              rvalid;
   logic [31:0]       rdata;
   logic [1:0]        rresp;
   logic              ctrl_hold;
   logic              sw_restart;
   logic              next_aw_have;
   logic [ADDR_W-1:0] next_aw_addr;
   logic              next_w_have;
   logic [31:0]       next_w_data;
   logic [3:0]        next_w_strb;
   logic              next_bvalid;
   logic [1:0]        next_bresp;
   logic              next_rvalid;
   logic [31:0]       next_rdata;
   logic [1:0]        next_rresp;
   logic              next_ctrl_hold;
   logic              next_sw_restart;

   // Block state
   eqs_state_e state;
   eqs_state_e next_state;
   logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_cnt;
   logic [$clog2(SETTLE_CYCLES+1)-1:0] next_settle_cnt;
   logic        settled;
   logic        next_settled;
   logic        color_ind;
   logic        invert_ind;
   logic        color_mode;
   logic        chain_inv;
   logic        reacquire;
   logic [15:0] restart_count;
   logic        next_color_mode;
   logic        next_chain_inv;
   logic        next_reacquire;
   logic [15:0] next_restart_count;
   logic        hold_eff;
   logic        restart_req;
   logic [31:0] status_word;

   eqs_tgl_if tgl_bus ();

   // Toggle detector watches the synchronised polarity pin
   assign tgl_bus.level      = sync_2[SYNC_INV];
   assign tgl_bus.ext        = sync_2[SYNC_INV_EXT];
   assign tgl_bus.standalone = !SERIAL_SELECT_I; // RQ13

   eqs_toggle_det u_toggle (
      .clk_i   (REF_CLK_I),
      .rst_n_i (RST_N_I),
      .tgl     (tgl_bus)
   );

   // Hold from the pin, possibly tied to the settled output, or from software
   assign hold_eff    = sync_2[SYNC_HOLD] | ctrl_hold; // RQ11 RQ12
   assign restart_req = tgl_bus.restart | sw_restart;

   // Status word seen by software
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ST_STATE_LSB +: 2] = state;
      status_word[ST_SETTLED_BIT]    = settled;
      status_word[ST_COLOR_BIT]      = color_mode;
      status_word[ST_INVERT_BIT]     = chain_inv;
      status_word[ST_COLOR_OVR_BIT]  = sync_2[SYNC_COLOR_EXT];
      status_word[ST_INV_OVR_BIT]    = sync_2[SYNC_INV_EXT];
      status_word[ST_HOLD_BIT]       = hold_eff;
      status_word[ST_BYPASS_BIT]     = EQUALIZER_BYPASS_I;
   end

   // AXI4-Lite slave next values
   always_comb begin
      next_aw_have    = aw_have;
      next_aw_addr    = aw_addr;
      next_w_have     = w_have;
      next_w_data     = w_data;
      next_w_strb     = w_strb;
      next_bvalid     = bvalid;
      next_bresp      = bresp;
      next_rvalid     = rvalid;
      next_rdata      = rdata;
      next_rresp      = rresp;
      next_ctrl_hold  = ctrl_hold;
      next_sw_restart = 1'b0;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
         next_aw_have = 1'b1;
         next_aw_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
         next_w_have = 1'b1;
         next_w_data = S_AXI_WDATA_I;
         next_w_strb = S_AXI_WSTRB_I;
      end
      if (aw_have && w_have) begin
         next_aw_have = 1'b0;
         next_w_have  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = RESP_OKAY;
         if (aw_addr[7:2] == REG_CTRL_OFS[7:2] && aw_addr[1:0] == 2'b00) begin
            if (w_strb[0]) begin
               next_ctrl_hold  = w_data[CTRL_HOLD_BIT];
               next_sw_restart = w_data[CTRL_RESTART_BIT];
            end
         end else if (aw_addr == REG_STATUS_OFS || aw_addr == REG_RESTART_OFS) begin
            next_bresp = RESP_OKAY; // Read-only registers ignore writes
         end else begin
            next_bresp = RESP_SLVERR;
         end
      end else if (bvalid && S_AXI_BREADY_I) begin
         next_bvalid = 1'b0;
      end
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         if (S_AXI_ARADDR_I == REG_CTRL_OFS) begin
            next_rdata = {31'h0000_0000, ctrl_hold};
         end else if (S_AXI_ARADDR_I == REG_STATUS_OFS) begin
            next_rdata = status_word;
         end else if (S_AXI_ARADDR_I == REG_RESTART_OFS) begin
            next_rdata = {16'h0000, restart_count};
         end else begin
            next_rdata = 32'h0000_0000;
            next_rresp = RESP_SLVERR;
         end
      end else if (rvalid && S_AXI_RREADY_I) begin
         next_rvalid = 1'b0;
      end
   end

   // AXI4-Lite slave registers
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         aw_have    <= 1'b0;
         aw_addr    <= '0;
         w_have     <= 1'b0;
         w_data     <= 32'h0000_0000;
         w_strb     <= 4'h0;
         bvalid     <= 1'b0;
         bresp      <= RESP_OKAY;
         rvalid     <= 1'b0;
         rdata      <= 32'h0000_0000;
         rresp      <= RESP_OKAY;
         ctrl_hold  <= CTRL_HOLD_RST;
         sw_restart <= 1'b0;
      end else begin
         aw_have    <= next_aw_have;
         aw_addr    <= next_aw_addr;
         w_have     <= next_w_have;
         w_data     <= next_w_data;
         w_strb     <= next_w_strb;
         bvalid     <= next_bvalid;
         bresp      <= next_bresp;
         rvalid     <= next_rvalid;
         rdata      <= next_rdata;
         rresp      <= next_rresp;
         ctrl_hold  <= next_ctrl_hold;
         sw_restart <= next_sw_restart;
      end
   end

   // Each address and data channel takes one beat until the response leaves
   assign S_AXI_AWREADY_O = !aw_have && !bvalid;
   assign S_AXI_WREADY_O  = !w_have && !bvalid;
   assign S_AXI_BVALID_O  = bvalid;
   assign S_AXI_BRESP_O   = bresp;
   assign S_AXI_ARREADY_O = !rvalid;
   assign S_AXI_RVALID_O  = rvalid;
   assign S_AXI_RDATA_O   = rdata;
   assign S_AXI_RRESP_O   = rresp;

   // Acquisition state machine; settles after a run of converged cycles
   always_comb begin
      next_state      = state;
      next_settle_cnt = settle_cnt;
      case (state)
         ST_IDLE: begin
            next_settle_cnt = '0;
            if (SIGNAL_PRESENT_I && !EQUALIZER_BYPASS_I) begin
               next_state = ST_ACQUIRE;
            end
         end
         ST_ACQUIRE: begin
            if (!SIGNAL_PRESENT_I || EQUALIZER_BYPASS_I) begin
               next_state = ST_IDLE; // RQ14
            end else if (restart_req) begin
               next_settle_cnt = '0; // RQ7
            end else if (EQ_CONVERGED_I) begin
               next_settle_cnt = settle_cnt + 1'b1;
               if (settle_cnt == SETTLE_CYCLES - 1) begin
                  next_state = ST_SETTLED; // RQ8
               end
            end else begin
               next_settle_cnt = '0;
            end
         end
         ST_SETTLED: begin
            next_settle_cnt = '0;
            if (!SIGNAL_PRESENT_I || EQUALIZER_BYPASS_I) begin
               next_state = ST_IDLE; // RQ8
            end else if (restart_req) begin
               next_state = ST_ACQUIRE; // RQ7
            end
         end
         default: begin
            next_state      = ST_IDLE;
            next_settle_cnt = '0;
         end
      endcase
      next_settled = (next_state == ST_SETTLED); // RQ8
   end

   // Mode selection: pin overrides win over detection
   always_comb begin
      next_color_mode    = sync_2[SYNC_COLOR_EXT] ? sync_2[SYNC_COLOR] : BURST_DETECTED_I; // RQ2
      next_chain_inv     = sync_2[SYNC_INV_EXT] ? sync_2[SYNC_INV] : POLARITY_INVERTED_I; // RQ5
      next_reacquire     = restart_req && (state != ST_IDLE);
      next_restart_count = restart_count;
      if (next_reacquire) begin
         next_restart_count = restart_count + 16'h0001;
      end
   end

   // Block state registers
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         state         <= ST_IDLE;
         settle_cnt    <= '0;
         settled       <= 1'b0;
         color_ind     <= 1'b0;
         invert_ind    <= 1'b0;
         color_mode    <= 1'b0;
         chain_inv     <= 1'b0;
         reacquire     <= 1'b0;
         restart_count <= 16'h0000;
      end else begin
         state         <= next_state;
         settle_cnt    <= next_settle_cnt;
         settled       <= next_settled;
         color_ind     <= BURST_DETECTED_I;    // RQ1
         invert_ind    <= POLARITY_INVERTED_I; // RQ4
         color_mode    <= next_color_mode;
         chain_inv     <= next_chain_inv;
         reacquire     <= next_reacquire;
         restart_count <= next_restart_count;
      end
   end

   // Weak drivers release while a strong outside driver is seen
   assign COLOR_O       = color_ind;
   assign COLOR_OE_N_O  = sync_2[SYNC_COLOR_EXT]; // RQ3
   assign INVERT_O      = invert_ind;
   assign INVERT_OE_N_O = sync_2[SYNC_INV_EXT];   // RQ6

   // Adaptation enable ignores the indicators, so a wrong one cannot stop it
   assign EQ_UPDATE_O    = !hold_eff && !EQUALIZER_BYPASS_I; // RQ10 RQ9 RQ14
   assign EQ_BYPASS_O    = EQUALIZER_BYPASS_I;               // RQ14
   assign EQ_SETTLED_O   = settled;
   assign COLOR_MODE_O   = color_mode;
   assign CHAIN_INVERT_O = chain_inv;
   assign REACQUIRE_O    = reacquire;

   a_color_ind_follow: assert property ( // RQ1
      1'b1 |=> COLOR_O == $past(BURST_DETECTED_I)) else $error("Chroma indicator wrong");

   a_color_force_mode: assert property ( // RQ2
      sync_2[SYNC_COLOR_EXT] |=> COLOR_MODE_O == $past(sync_2[SYNC_COLOR]))
      else $error("Chroma override ignored");

   a_color_weak_drive: assert property ( // RQ3
      $past(RST_N_I, 2) && !$past(COLOR_EXT_I, 2) |-> !COLOR_OE_N_O)
      else $error("Chroma pin not driven");

   a_invert_ind_follow: assert property ( // RQ4
      1'b1 |=> INVERT_O == $past(POLARITY_INVERTED_I)) else $error("Polarity indicator wrong");

   a_invert_force_chain: assert property ( // RQ5
      sync_2[SYNC_INV_EXT] |=> CHAIN_INVERT_O == $past(sync_2[SYNC_INV]))
      else $error("Polarity override ignored");

   a_invert_release: assert property ( // RQ6
      $past(RST_N_I, 2) && $past(INVERT_EXT_I, 2) |-> INVERT_OE_N_O)
      else $error("Polarity pin fights driver");

   a_reacquire_pulse: assert property ( // RQ7
      tgl_bus.restart && state == ST_SETTLED |=> REACQUIRE_O && !EQ_SETTLED_O)
      else $error("Toggle did not restart");

   a_settled_absent: assert property ( // RQ8
      !SIGNAL_PRESENT_I |=> !EQ_SETTLED_O) else $error("Settled without signal");

   a_settled_needs_run: assert property ( // RQ8
      $rose(EQ_SETTLED_O) |-> $past(EQ_CONVERGED_I, 2) && $past(settle_cnt) == SETTLE_CYCLES - 1)
      else $error("Settled too early");

   a_update_hold: assert property ( // RQ10
      $past(RST_N_I, 2) && $past(HOLD_I, 2) |-> !EQ_UPDATE_O) else $error("Hold not honoured");

   a_bypass_stop: assert property ( // RQ14
      EQUALIZER_BYPASS_I |-> !EQ_UPDATE_O ##1 !EQ_SETTLED_O)
      else $error("Bypass did not stop equalizer");

endmodule // eqs_status_pins

// file: verification/eqs_pin_model.sv
// Board-side model of one weakly driven indicator pin with optional override
`timescale 1ns/1ps
module eqs_pin_model (
   input  wire logic drive_i,
   input  wire logic val_i,
   input  wire logic dut_i,
   input  wire logic dut_oe_n_i,
   output wire logic pin_o,
   output wire logic ext_o
);
   // Strong board driver wins; weak device drive otherwise; undriven pin drifts
   assign pin_o = drive_i ? val_i : (dut_oe_n_i ? ~dut_i : dut_i);
   // Pad sense of the strong outside driver
   assign ext_o = drive_i;
endmodule // eqs_pin_model

// file: verification/tb.sv
// Self-checking bench of the equalizer status and override logic
`timescale 1ns/1ps
module tb;
   import eqs_pkg::*;
   logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d, st_exp;
   logic [1:0]  bresp, rresp, r;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        sig, conv, burst, pol, hold, byp, ssel, cdrv, cval, idrv, ival;
   logic        cpin, cext, co, coe_n, ipin, iext, io, ioe_n;
   logic        settled, upd, bypo, cmode, cinv, reacq;
   int          failures, n_checks, n;

   eqs_pin_model u_cpin (.drive_i(cdrv), .val_i(cval), .dut_i(co), .dut_oe_n_i(coe_n),
      .pin_o(cpin), .ext_o(cext));
   eqs_pin_model u_ipin (.drive_i(idrv), .val_i(ival), .dut_i(io), .dut_oe_n_i(ioe_n),
      .pin_o(ipin), .ext_o(iext));

   eqs_status_pins DUT (.REF_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
      .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready), .SIGNAL_PRESENT_I(sig), .EQ_CONVERGED_I(conv),
      .BURST_DETECTED_I(burst), .POLARITY_INVERTED_I(pol), .COLOR_I(cpin),
      .COLOR_EXT_I(cext), .COLOR_O(co), .COLOR_OE_N_O(coe_n), .INVERT_I(ipin),
      .INVERT_EXT_I(iext), .INVERT_O(io), .INVERT_OE_N_O(ioe_n), .HOLD_I(hold),
      .EQUALIZER_BYPASS_I(byp), .SERIAL_SELECT_I(ssel), .EQ_SETTLED_O(settled),
      .EQ_UPDATE_O(upd), .EQ_BYPASS_O(bypo), .COLOR_MODE_O(cmode),
      .CHAIN_INVERT_O(cinv), .REACQUIRE_O(reacq));

   // Clock of 5 ns period
   always #2.5 clk = ~clk;

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Write one word; valids held until their handshake edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic ha, hw, hb;
      rs = 2'bxx;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(negedge clk);
         ha = awvalid & awready;
         hw = wvalid & wready;
         hb = bvalid;
         if (hb) rs = bresp;
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) bready <= 1'b0;
         if (hb) break;
      end
   endtask

   // Read one word; address held until taken, rready until data seen
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ha, hr;
      rs = 2'bxx;
      v = 'x;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(negedge clk);
         ha = arvalid & arready;
         hr = rvalid;
         if (hr) v = rdata;
         if (hr) rs = rresp;
         @(posedge clk);
         if (ha) arvalid <= 1'b0;
         if (hr) rready <= 1'b0;
         if (hr) break;
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      summarize();
   end

   // Main sequence
   initial begin
      clk = 0; rst_n = 0; failures = 0; n_checks = 0;
      {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      {sig, conv, burst, pol, byp, cdrv, cval, idrv, ival} = '0;
      hold = 0;
      ssel = 0;
      cyc(4);
      rst_n <= 1'b1;
      cyc(1);
      chk("settled", settled, 0);
      axi_rd(8'hfc, d, r);
      chk("unmapped resp", r, RESP_SLVERR);
      $display("test reset done");
      for (int v = 0; v < 2; v++) begin
         burst <= v[0];
         pol <= v[0];
         cyc(3);
         chk("color", co, v);
         chk("color mode", cmode, v);
         chk("color oe_n", coe_n, 0);
         chk("invert", io, v);
         chk("chain invert", cinv, v);
         chk("invert oe_n", ioe_n, 0);
      end
      $display("test indicators done");
      for (int v = 0; v < 2; v++) begin
         cdrv <= 1'b1;
         cval <= v[0];
         idrv <= 1'b1;
         ival <= v[0];
         cyc(5);
         chk("color oe_n", coe_n, 1);
         chk("color mode", cmode, v);
         chk("invert oe_n", ioe_n, 1);
         chk("chain invert", cinv, v);
      end
      cdrv <= 1'b0;
      idrv <= 1'b0;
      $display("test overrides done");
      sig <= 1'b1;
      conv <= 1'b1;
      cyc(100);
      chk("settled early", settled, 0);
      cyc(SETTLE_CYCLES);
      chk("settled", settled, 1);
      axi_rd(REG_STATUS_OFS, d, r);
      st_exp = 32'(ST_SETTLED) << ST_STATE_LSB;
      st_exp |= (32'h1 << ST_SETTLED_BIT) | (32'h1 << ST_COLOR_BIT) | (32'h1 << ST_INVERT_BIT);
      chk("status", d, st_exp);
      hold <= settled;
      cyc(1);
      chk("update unsynced", upd, 1);
      cyc(3);
      chk("update held", upd, 0);
      hold <= 1'b0;
      cyc(4);
      chk("update free", upd, 1);
      axi_wr(REG_CTRL_OFS, 32'h1, r);
      #1;
      chk("update ctrl hold", upd, 0);
      axi_rd(REG_CTRL_OFS, d, r);
      chk("ctrl", d, 32'h1);
      axi_wr(REG_CTRL_OFS, 32'h0, r);
      chk("write resp", r, RESP_OKAY);
      $display("test hold done");
      for (int s = 0; s < 2; s++) begin
         ssel <= s[0];
         ival <= 1'b1;
         idrv <= 1'b1;
         cyc(6);
         ival <= 1'b0;
         cyc(6);
         ival <= 1'b1;
         n = 0;
         repeat (20) begin
            cyc(1);
            n += reacq;
         end
         chk("restart pulses", n, s == 0);
         chk("settled after restart", settled, 0);
      end
      axi_rd(REG_RESTART_OFS, d, r);
      chk("restart count", d, 1);
      $display("test toggle done");
      cyc(SETTLE_CYCLES);
      chk("settled again", settled, 1);
      byp <= 1'b1;
      cyc(2);
      chk("bypass", bypo, 1);
      chk("update bypass", upd, 0);
      chk("settled bypass", settled, 0);
      $display("test bypass done");
      summarize();
   end
endmodule // tb
